/* File: src/mal_consts.svh */
/*
  Constants of the max-address command block: task-file offsets, opcodes, fields, limits, host register map.
  Assumes inclusion by both ends and by the package users.
*/
`ifndef MAL_CONSTS_SVH
`define MAL_CONSTS_SVH
`define MAL_TF_FEAT 3'h1
`define MAL_TF_CNT 3'h2
`define MAL_TF_SNUM 3'h3
`define MAL_TF_CLO 3'h4
`define MAL_TF_CHI 3'h5
`define MAL_TF_DH 3'h6
`define MAL_TF_CMD 3'h7
`define MAL_OP_SETMAX 8'hF9
`define MAL_OP_NATIVE 8'hF8
`define MAL_FEAT_PWD 8'h01
`define MAL_FEAT_LOCK 8'h02
`define MAL_DH_LBA_BIT 6
`define MAL_VV_BIT 0
`define MAL_CYL_CAP 16'h3FFF
`define MAL_W54_CAP 32'h0000_FFFF
`define MAL_CAP_LIM 32'h00FB_FC10
`define MAL_PWD_FIRST 8'h01
`define MAL_PWD_LAST 8'h10
`define MAL_SECT_LAST 8'hFF
`define MAL_A_TF0 8'h00
`define MAL_A_TF1 8'h04
`define MAL_A_CMD 8'h08
`define MAL_A_STAT 8'h0C
`define MAL_A_RET 8'h10
`define MAL_A_PWD 8'h20
`define MAL_A_PWD_END 8'h3C
`endif

/* File: src/mal_dev.sv */
/*
  Device end: decodes max-address commands from the task file, keeps identify words, lock and password.
  Assumes host writes feature and address registers before the opcode, one write per clock.
*/
// Design decision made here: the task-file link port.
// Summary of operation
// - feature 01H with F9H sets password
// - address set only right after native read
// - head register bit 6 picks LBA or CHS
// - head bits 3:0 are head or LBA 27:24
// - cylinder and sector registers carry remaining address
// - volatility bit decides survival over hardware reset
// - accesses above the maximum get ID-not-found
// - identify words follow the new maximum
// - second non-volatile set answers ID-not-found
// - failed set leaves maximum and words untouched
// - CHS: word 1 is cylinder+1, capped 16383
// - CHS: capacity is words 1*3*6
// - CHS: word 54 capped quotient, 58:57 product
// - LBA: capacity is maximum address plus one
// - LBA without CHS: geometry words zeroed only for capacity above 16514064
// - LBA with CHS: word 1 quotient or 16383
// - LBA with CHS: word 54 quotient or 16383
// - password in words 1-16 of one sector
// - password held; accepting it locks
// - lock subcommand 02H locks, rejecting others
// - lock stays until power cycle
// - after native read, subcommands become address set
`timescale 1ns/100ps
`default_nettype none
`include "mal_consts.svh"
module mal_dev #(
  parameter logic [27:0] NATIVE_MAX = 28'h03F_FFFF,
  parameter logic [15:0] GEO_HEADS = 16'h0010,
  parameter logic [15:0] GEO_SECTS = 16'h003F,
  parameter bit CHS_SUP = 1'b1
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  mal_if.dev LNK,
  input wire logic HW_RESET,
  input wire logic ACC_REQ,
  input wire logic [27:0] ACC_LBA,
  output logic ACC_OK,
  output logic ACC_IDNF,
  input wire logic [3:0] PWD_IDX,
  output logic [15:0] PWD_WORD,
  output logic LOCKED,
  output mal_pkg::mal_id_t ID_WORDS
);
  localparam logic [31:0] CAP0 = {4'h0, NATIVE_MAX} + 32'h0000_0001;
  localparam logic [31:0] HS = 32'(GEO_HEADS) * 32'(GEO_SECTS);
  localparam logic [31:0] W1Q = (CAP0 / HS > `MAL_W54_CAP) ? `MAL_W54_CAP : CAP0 / HS;
  localparam logic [15:0] W1D = (CAP0 < `MAL_CAP_LIM) ? W1Q[15:0] : `MAL_CYL_CAP;
  localparam logic [15:0] W54D = (CAP0 < `MAL_CAP_LIM) ? W1Q[15:0] : `MAL_CYL_CAP;
  localparam logic [31:0] W5857D = 32'(W54D) * HS;
  localparam mal_pkg::mal_id_t ID_RST = '{W1D, GEO_HEADS, GEO_SECTS, W54D, GEO_HEADS, GEO_SECTS, W5857D, CAP0};

  mal_pkg::mal_dst_t state_ff;
  logic [7:0] feat_ff, cnt_ff, snum_ff, clo_ff, chi_ff, dh_ff;
  logic hw_m_ff, hw_s_ff;
  logic after_native_ff, nv_done_ff;
  logic [31:0] s_cap_ff;
  logic [15:0] s_w1_ff, s_w54_ff;
  logic s_zero_ff, s_nv_ff;
  logic div_start_ff;
  logic [31:0] div_num_ff, div_den_ff, div_q;
  logic div_done;
  logic [7:0] wcnt_ff;
  logic [15:0] pwd_ff [0:15];
  mal_pkg::mal_id_t nv_id_ff, new_id;
  logic is_cmd, lba_mode, vv, over, do_commit;
  logic [15:0] cyl, w1c, qcap;
  logic [31:0] lba_cap, chs_cap, chs_num;

  assign is_cmd = LNK.tf_wr && (LNK.tf_addr == `MAL_TF_CMD);
  assign lba_mode = dh_ff[`MAL_DH_LBA_BIT];
  assign vv = cnt_ff[`MAL_VV_BIT];
  assign cyl = {chi_ff, clo_ff};
  assign w1c = (cyl >= `MAL_CYL_CAP) ? `MAL_CYL_CAP : cyl + 16'h0001;
  assign chs_cap = 32'(w1c) * 32'(ID_WORDS.w3) * 32'(ID_WORDS.w6);
  assign chs_num = (chs_cap < `MAL_CAP_LIM) ? chs_cap : `MAL_CAP_LIM;
  assign lba_cap = {4'h0, dh_ff[3:0], chi_ff, clo_ff, snum_ff} + 32'h0000_0001;
  assign qcap = (div_q > `MAL_W54_CAP) ? 16'hFFFF : div_q[15:0];
  assign over = s_cap_ff > CAP0;
  assign do_commit = (state_ff == mal_pkg::D_COMMIT) && !over;

  always_comb begin
    new_id = ID_WORDS; // keep words 3 6 55 56
    new_id.w6061 = s_cap_ff;
    new_id.w1 = s_w1_ff;
    new_id.w54 = s_w54_ff;
    new_id.w5857 = 32'(s_w54_ff) * 32'(ID_WORDS.w55) * 32'(ID_WORDS.w56);
    if (s_zero_ff) begin
      new_id = '0;
      new_id.w6061 = s_cap_ff;
    end
  end

  mal_div #(.W(32)) u_div (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .start(div_start_ff),
    .num(div_num_ff),
    .den(div_den_ff),
    .done(div_done),
    .quo(div_q)
  );

  // hardware reset pin is asynchronous to the core clock
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      hw_m_ff <= 1'b0;
      hw_s_ff <= 1'b0;
    end else begin
      hw_m_ff <= HW_RESET;
      hw_s_ff <= hw_m_ff;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      {feat_ff, cnt_ff, snum_ff, clo_ff, chi_ff, dh_ff} <= '0;
    end else if (LNK.tf_wr) begin
      case (LNK.tf_addr)
        `MAL_TF_FEAT: feat_ff <= LNK.tf_wdata;
        `MAL_TF_CNT: cnt_ff <= LNK.tf_wdata;
        `MAL_TF_SNUM: snum_ff <= LNK.tf_wdata;
        `MAL_TF_CLO: clo_ff <= LNK.tf_wdata;
        `MAL_TF_CHI: chi_ff <= LNK.tf_wdata;
        `MAL_TF_DH: dh_ff <= LNK.tf_wdata;
        default: ;
      endcase
    end
  end

  // identify words and the non-volatile snapshot; only a clean commit or a hardware reset touches them
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ID_WORDS <= ID_RST;
      nv_id_ff <= ID_RST;
      nv_done_ff <= 1'b0;
    end else if (hw_s_ff) begin
      ID_WORDS <= nv_id_ff;
      nv_done_ff <= 1'b0;
    end else if (do_commit) begin
      ID_WORDS <= new_id;
      if (s_nv_ff) begin
        nv_id_ff <= new_id;
        nv_done_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ACC_OK <= 1'b0;
      ACC_IDNF <= 1'b0;
    end else begin
      ACC_IDNF <= ACC_REQ && ({4'h0, ACC_LBA} >= ID_WORDS.w6061);
      ACC_OK <= ACC_REQ && ({4'h0, ACC_LBA} < ID_WORDS.w6061);
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < 16; i++) begin
        pwd_ff[i] <= '0;
      end
      PWD_WORD <= '0;
    end else begin
      PWD_WORD <= pwd_ff[PWD_IDX];
      if (state_ff == mal_pkg::D_PWD && LNK.dat_vld && wcnt_ff >= `MAL_PWD_FIRST && wcnt_ff <= `MAL_PWD_LAST) begin
        pwd_ff[4'(wcnt_ff - `MAL_PWD_FIRST)] <= LNK.dat;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= mal_pkg::D_IDLE;
      after_native_ff <= 1'b0;
      LOCKED <= 1'b0;
      LNK.drq <= 1'b0;
      LNK.done <= 1'b0;
      LNK.err_abort <= 1'b0;
      LNK.err_idnf <= 1'b0;
      LNK.ret_max <= '0;
      s_cap_ff <= '0;
      s_w1_ff <= '0;
      s_w54_ff <= '0;
      s_zero_ff <= 1'b0;
      s_nv_ff <= 1'b0;
      div_start_ff <= 1'b0;
      div_num_ff <= '0;
      div_den_ff <= '0;
      wcnt_ff <= '0;
    end else begin
      LNK.done <= 1'b0;
      div_start_ff <= 1'b0;
      if (hw_s_ff) begin
        after_native_ff <= 1'b0;
      end
      case (state_ff)
        mal_pkg::D_IDLE: begin
          if (is_cmd) begin
            LNK.err_abort <= 1'b0;
            LNK.err_idnf <= 1'b0;
            after_native_ff <= 1'b0;
            LNK.done <= 1'b1;
            if (LNK.tf_wdata == `MAL_OP_NATIVE) begin
              LNK.ret_max <= NATIVE_MAX;
              after_native_ff <= 1'b1;
            end else if (LNK.tf_wdata != `MAL_OP_SETMAX) begin
              LNK.err_abort <= 1'b1;
            end else if (after_native_ff) begin
              if (LOCKED) begin
                LNK.err_abort <= 1'b1;
              end else if (vv && nv_done_ff) begin
                LNK.err_idnf <= 1'b1;
              end else begin
                LNK.done <= 1'b0;
                s_nv_ff <= vv;
                s_zero_ff <= 1'b0;
                div_start_ff <= 1'b1;
                if (lba_mode) begin
                  s_cap_ff <= lba_cap;
                  div_num_ff <= lba_cap;
                  div_den_ff <= 32'(ID_WORDS.w3) * 32'(ID_WORDS.w6);
                  state_ff <= mal_pkg::D_DIV1;
                  if (lba_cap >= `MAL_CAP_LIM) begin
                    div_start_ff <= 1'b0;
                    state_ff <= mal_pkg::D_COMMIT;
                    s_w1_ff <= `MAL_CYL_CAP;
                    s_w54_ff <= `MAL_CYL_CAP;
                    s_zero_ff <= !CHS_SUP && (lba_cap > `MAL_CAP_LIM);
                  end
                end else begin
                  s_cap_ff <= chs_cap;
                  s_w1_ff <= w1c;
                  div_num_ff <= chs_num;
                  div_den_ff <= 32'(ID_WORDS.w55) * 32'(ID_WORDS.w56);
                  state_ff <= mal_pkg::D_DIV54;
                end
              end
            end else if (LOCKED) begin
              LNK.err_abort <= 1'b1;
            end else if (feat_ff == `MAL_FEAT_PWD) begin
              LNK.done <= 1'b0;
              LNK.drq <= 1'b1;
              wcnt_ff <= '0;
              state_ff <= mal_pkg::D_PWD;
            end else if (feat_ff == `MAL_FEAT_LOCK) begin
              LOCKED <= 1'b1;
            end else begin
              LNK.err_abort <= 1'b1;
            end
          end
        end
        mal_pkg::D_DIV1: begin
          if (div_done) begin
            s_w1_ff <= qcap;
            div_num_ff <= s_cap_ff;
            div_den_ff <= 32'(ID_WORDS.w55) * 32'(ID_WORDS.w56);
            div_start_ff <= 1'b1;
            state_ff <= mal_pkg::D_DIV54;
          end
        end
        mal_pkg::D_DIV54: begin
          if (div_done) begin
            s_w54_ff <= qcap;
            state_ff <= mal_pkg::D_COMMIT;
          end
        end
        mal_pkg::D_COMMIT: begin
          LNK.done <= 1'b1;
          LNK.err_abort <= over;
          state_ff <= mal_pkg::D_WAIT;
        end
        mal_pkg::D_PWD: begin
          if (LNK.dat_vld) begin
            wcnt_ff <= wcnt_ff + 8'h01;
            if (wcnt_ff == `MAL_SECT_LAST) begin
              LNK.drq <= 1'b0;
              LNK.done <= 1'b1;
              LOCKED <= 1'b1;
              state_ff <= mal_pkg::D_IDLE;
            end
          end
        end
        mal_pkg::D_WAIT: state_ff <= mal_pkg::D_IDLE;
        default: state_ff <= mal_pkg::D_IDLE;
      endcase
    end
  end
endmodule : mal_dev
`default_nettype wire

/* File: src/mal_div.sv */
/*
  Serial restoring divider, one quotient bit per clock.
  Assumes start only while idle; divide by zero gives all ones.
*/
`timescale 1ns/100ps
`default_nettype none
module mal_div #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [W-1:0] num,
  input wire logic [W-1:0] den,
  output logic done,
  output logic [W-1:0] quo
);
  logic [W:0] rem_ff;
  logic [W-1:0] den_ff;
  logic [$clog2(W+1)-1:0] cnt_ff;
  logic [W:0] trial;

  assign trial = {rem_ff[W-1:0], quo[W-1]} - {1'b0, den_ff};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rem_ff <= '0;
      den_ff <= '0;
      quo <= '0;
      cnt_ff <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        rem_ff <= '0;
        den_ff <= den;
        quo <= num;
        cnt_ff <= ($clog2(W+1))'(W);
      end else if (cnt_ff != '0) begin
        if (!trial[W]) begin
          rem_ff <= trial;
          quo <= {quo[W-2:0], 1'b1};
        end else begin
          rem_ff <= {rem_ff[W-1:0], quo[W-1]};
          quo <= {quo[W-2:0], 1'b0};
        end
        cnt_ff <= cnt_ff - 1'b1;
        done <= (cnt_ff == 1);
      end
    end
  end
endmodule : mal_div
`default_nettype wire

/* File: src/mal_host.sv */
/*
  Host end: APB registers take a task-file command, play it onto the link and collect the answer.
  Assumes an APB master on CLK_SYS and the device end on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mal_consts.svh"
module mal_host (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  mal_if.host LNK
);
  mal_pkg::mal_hst_t state_ff;
  logic [31:0] tf0_ff;
  logic [15:0] tf1_ff;
  logic [7:0] op_ff;
  logic busy_ff, abort_ff, idnf_ff, native_ok_ff, nv_sent_ff;
  logic [27:0] ret_ff;
  logic [31:0] pwd_ff [0:7];
  logic [2:0] idx_ff;
  logic [7:0] wcnt_ff;
  logic acc, wr_go, mapped, nv_set;
  logic [31:0] rd_val;
  logic [7:0] wbyte, wsel;

  assign acc = PSEL && PENABLE && !PREADY;
  assign wr_go = PSEL && PENABLE && PREADY && PWRITE;
  assign mapped = PADDR[1:0] == 2'b00 && (PADDR <= `MAL_A_RET || (PADDR >= `MAL_A_PWD && PADDR <= `MAL_A_PWD_END));
  // a set-address that follows a good native read and asks to be non-volatile
  assign nv_set = op_ff == `MAL_OP_SETMAX && native_ok_ff && tf1_ff[`MAL_VV_BIT];
  assign wsel = wcnt_ff - `MAL_PWD_FIRST;

  always_comb begin
    case (PADDR)
      `MAL_A_TF0: rd_val = tf0_ff;
      `MAL_A_TF1: rd_val = {16'h0000, tf1_ff};
      `MAL_A_CMD: rd_val = {24'h00_0000, op_ff};
      `MAL_A_STAT: rd_val = {28'h000_0000, nv_sent_ff, idnf_ff, abort_ff, busy_ff};
      `MAL_A_RET: rd_val = {4'h0, ret_ff};
      default: rd_val = PADDR >= `MAL_A_PWD ? pwd_ff[PADDR[4:2]] : 32'h0000_0000;
    endcase
    case (idx_ff)
      `MAL_TF_FEAT: wbyte = tf1_ff[15:8];
      `MAL_TF_CNT: wbyte = tf1_ff[7:0];
      `MAL_TF_SNUM: wbyte = tf0_ff[7:0];
      `MAL_TF_CLO: wbyte = tf0_ff[15:8];
      `MAL_TF_CHI: wbyte = tf0_ff[23:16];
      `MAL_TF_DH: wbyte = tf0_ff[31:24];
      default: wbyte = op_ff;
    endcase
  end

  // one wait state so that read data and answer come from flops
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= '0;
    end else begin
      PREADY <= acc;
      PSLVERR <= acc && !mapped;
      PRDATA <= acc && mapped && !PWRITE ? rd_val : 32'h0000_0000;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      tf0_ff <= '0;
      tf1_ff <= '0;
      for (int i = 0; i < 8; i++) begin
        pwd_ff[i] <= '0;
      end
    end else if (wr_go && mapped) begin
      case (PADDR)
        `MAL_A_TF0: tf0_ff <= PWDATA;
        `MAL_A_TF1: tf1_ff <= PWDATA[15:0];
        default: if (PADDR >= `MAL_A_PWD) pwd_ff[PADDR[4:2]] <= PWDATA;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= mal_pkg::H_IDLE;
      op_ff <= '0;
      busy_ff <= 1'b0;
      abort_ff <= 1'b0;
      idnf_ff <= 1'b0;
      ret_ff <= '0;
      native_ok_ff <= 1'b0;
      nv_sent_ff <= 1'b0;
      idx_ff <= '0;
      wcnt_ff <= '0;
      LNK.tf_wr <= 1'b0;
      LNK.tf_addr <= '0;
      LNK.tf_wdata <= '0;
      LNK.dat_vld <= 1'b0;
      LNK.dat <= '0;
    end else begin
      case (state_ff)
        mal_pkg::H_IDLE: begin
          if (wr_go && PADDR == `MAL_A_CMD) begin
            op_ff <= PWDATA[7:0];
            abort_ff <= 1'b0;
            idnf_ff <= 1'b0;
            busy_ff <= 1'b1;
            idx_ff <= `MAL_TF_FEAT;
            state_ff <= mal_pkg::H_WR;
          end
        end
        mal_pkg::H_WR: begin
          if (idx_ff == `MAL_TF_FEAT && nv_set && nv_sent_ff) begin
            idnf_ff <= 1'b1;
            busy_ff <= 1'b0;
            native_ok_ff <= 1'b0;
            state_ff <= mal_pkg::H_IDLE;
          end else begin
            LNK.tf_wr <= 1'b1;
            LNK.tf_addr <= idx_ff;
            LNK.tf_wdata <= wbyte;
            idx_ff <= idx_ff + 3'h1;
            if (idx_ff == `MAL_TF_CMD) begin
              state_ff <= mal_pkg::H_WAIT;
            end
          end
        end
        mal_pkg::H_WAIT: begin
          LNK.tf_wr <= 1'b0;
          LNK.dat_vld <= 1'b0;
          if (LNK.done) begin
            busy_ff <= 1'b0;
            abort_ff <= LNK.err_abort;
            idnf_ff <= LNK.err_idnf;
            ret_ff <= LNK.ret_max;
            native_ok_ff <= op_ff == `MAL_OP_NATIVE && !LNK.err_abort && !LNK.err_idnf;
            if (nv_set && !LNK.err_abort && !LNK.err_idnf) begin
              nv_sent_ff <= 1'b1;
            end
            state_ff <= mal_pkg::H_IDLE;
          end else if (LNK.drq && !LNK.dat_vld) begin
            wcnt_ff <= '0;
            state_ff <= mal_pkg::H_DATA;
          end
        end
        mal_pkg::H_DATA: begin
          LNK.dat_vld <= 1'b1;
          LNK.dat <= 16'h0000;
          if (wcnt_ff >= `MAL_PWD_FIRST && wcnt_ff <= `MAL_PWD_LAST) begin
            LNK.dat <= wsel[0] ? pwd_ff[wsel[3:1]][31:16] : pwd_ff[wsel[3:1]][15:0];
          end
          wcnt_ff <= wcnt_ff + 8'h01;
          if (wcnt_ff == `MAL_SECT_LAST) begin
            state_ff <= mal_pkg::H_WAIT;
          end
        end
        default: state_ff <= mal_pkg::H_IDLE;
      endcase
    end
  end
endmodule : mal_host
`default_nettype wire

/* File: src/mal_if.sv */
/*
  Link between task-file host and max-address device: register writes, data words, completion.
  Assumes both ends on the same clock; the bench supplies no wire resolution.
*/
`timescale 1ns/100ps
`default_nettype none
interface mal_if;
  logic tf_wr;
  logic [2:0] tf_addr;
  logic [7:0] tf_wdata;
  logic drq;
  logic dat_vld;
  logic [15:0] dat;
  logic done;
  logic err_abort;
  logic err_idnf;
  logic [27:0] ret_max;
  modport dev (input tf_wr, tf_addr, tf_wdata, dat_vld, dat, output drq, done, err_abort, err_idnf, ret_max);
  modport host (output tf_wr, tf_addr, tf_wdata, dat_vld, dat, input drq, done, err_abort, err_idnf, ret_max);
endinterface : mal_if
`default_nettype wire

/* File: src/mal_pkg.sv */
/*
  Types of the max-address command block: state encodings and identify-word record.
  Assumes mal_consts.svh for all numeric constants.
*/
package mal_pkg;
  typedef enum logic [5:0] {
    D_IDLE = 6'b00_0001,
    D_DIV1 = 6'b00_0010,
    D_DIV54 = 6'b00_0100,
    D_COMMIT = 6'b00_1000,
    D_PWD = 6'b01_0000,
    D_WAIT = 6'b10_0000
  } mal_dst_t;
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_WR = 4'b0010,
    H_WAIT = 4'b0100,
    H_DATA = 4'b1000
  } mal_hst_t;
  typedef struct packed {
    logic [15:0] w1;
    logic [15:0] w3;
    logic [15:0] w6;
    logic [15:0] w54;
    logic [15:0] w55;
    logic [15:0] w56;
    logic [31:0] w5857;
    logic [31:0] w6061;
  } mal_id_t;
endpackage : mal_pkg

/* File: test/mal_properties.sv */
/*
  Link checker: watches the task-file link between the host and device ends.
  Assumes one clock and the link signals handed in by name.
*/
`timescale 1ns/100ps
`default_nettype none
module mal_properties #(
  parameter logic [27:0] NATIVE_MAX = 28'h03F_FFFF
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic tf_wr,
  input wire logic [2:0] tf_addr,
  input wire logic [7:0] tf_wdata,
  input wire logic drq,
  input wire logic dat_vld,
  input wire logic [15:0] dat,
  input wire logic done,
  input wire logic err_abort,
  input wire logic err_idnf,
  input wire logic [27:0] ret_max
);
  logic op;
  logic [8:0] word_cnt_ff;
  assign op = tf_wr && tf_addr == 3'h7;
  // restarts on each opcode so a short sector cannot hide behind an old count
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      word_cnt_ff <= 9'h000;
    end else if (op) begin
      word_cnt_ff <= 9'h000;
    end else if (dat_vld) begin
      word_cnt_ff <= word_cnt_ff + 9'h001;
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  bad_opcode_a: assert property (op && tf_wdata != 8'hF9 && tf_wdata != 8'hF8 |=> done && err_abort)
    else $error("unknown opcode not aborted");
  native_answer_a: assert property (op && tf_wdata == 8'hF8 |=> done && !err_abort ##1 ret_max == NATIVE_MAX)
    else $error("native read answer wrong");
  cmd_finish_a: assert property (op |-> ##[1:120] (done || drq))
    else $error("command never answered");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  err_excl_a: assert property (done |-> !(err_abort && err_idnf))
    else $error("two error kinds at once");
  err_hold_a: assert property ($changed(err_abort) || $changed(err_idnf) |-> done || $past(op))
    else $error("error flag moved outside a command");
  ret_hold_a: assert property ($changed(ret_max) |-> done || $past(done))
    else $error("native max moved outside done");
  drq_start_a: assert property ($rose(drq) |-> $past(op) && $past(tf_wdata) == 8'hF9)
    else $error("data request without set opcode");
  drq_end_a: assert property ($fell(drq) |-> done && !err_abort && word_cnt_ff == 9'h100)
    else $error("password sector not closed after 256 words");
  word_inside_a: assert property (dat_vld |-> drq)
    else $error("data word outside request");
  cover property (op && tf_wdata == 8'hF9 ##1 drq);
  cover property (done && err_abort);
  cover property (done && !err_abort && !err_idnf);
endmodule : mal_properties
`default_nettype wire

/* File: test/max_address_limit_commands_tb.sv */
/*
  Bench: host and device ends joined by the link, APB driven, expected words from integer arithmetic.
  Assumes the design files are compiled first, device with its default geometry (16 heads, 63 sectors).
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module max_address_limit_commands_tb;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, hw_rst, acc_req, acc_ok, acc_idnf, locked, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [27:0] acc_lba;
  logic [3:0] pwd_idx;
  logic [15:0] pwd_word;
  logic [31:0] pw [8];
  mal_pkg::mal_id_t idw;
  int fail_count, check_count, seed, cap, capf, w1f, lba;
  // native capacity above the geometry limit so the 16383 branches are reachable
  localparam logic [27:0] native_max = 28'h0FF_FFFF;
  mal_if lnk();
  mal_host i_mal_host(.CLK_SYS(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LNK(lnk.host));
  mal_dev #(.NATIVE_MAX(native_max)) i_mal_dev(.CLK_SYS(clk), .RSTN(rstn), .LNK(lnk.dev), .HW_RESET(hw_rst),
    .ACC_REQ(acc_req), .ACC_LBA(acc_lba), .ACC_OK(acc_ok), .ACC_IDNF(acc_idnf), .PWD_IDX(pwd_idx),
    .PWD_WORD(pwd_word), .LOCKED(locked), .ID_WORDS(idw));
  mal_properties #(.NATIVE_MAX(native_max)) i_mal_properties(.CLK_SYS(clk), .RSTN(rstn), .tf_wr(lnk.tf_wr),
    .tf_addr(lnk.tf_addr), .tf_wdata(lnk.tf_wdata), .drq(lnk.drq), .dat_vld(lnk.dat_vld), .dat(lnk.dat),
    .done(lnk.done), .err_abort(lnk.err_abort), .err_idnf(lnk.err_idnf), .ret_max(lnk.ret_max));
  task complete_run;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n == 20) begin
      fail_count++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb
  // busy poll is bounded; a password sector needs some 260 cycles
  task cmd(input logic [7:0] op, input logic [31:0] tf0, input logic [15:0] tf1);
    apb(1'h1, 8'h00, tf0);
    apb(1'h1, 8'h04, {16'h0000, tf1});
    apb(1'h1, 8'h08, {24'h00_0000, op});
    rd = 32'h0000_0001;
    for (int i = 0; i < 200 && rd[0] !== 1'h0; i++) apb(1'h0, 8'h0C, 32'h0000_0000);
    if (rd[0] !== 1'h0) begin
      fail_count++;
      complete_run();
    end
  endtask : cmd
  // 1008 = heads times sectors, for words 3*6 and 55*56 alike
  function automatic int geo(input int c);
    return (c / 1008 > 65535) ? 65535 : c / 1008;
  endfunction : geo
  task chk_id(input int c, input int a, input int b);
    `CHK("cap", c, idw.w6061)
    `CHK("w1", a, idw.w1)
    `CHK("w54", b, idw.w54)
    `CHK("w5857", b * 1008, idw.w5857)
    `CHK("w3", 16, idw.w3)
    `CHK("w6", 63, idw.w6)
    `CHK("w55", 16, idw.w55)
    `CHK("w56", 63, idw.w56)
  endtask : chk_id
  task acc(input logic [27:0] a, input logic ok);
    acc_req <= 1'h1;
    acc_lba <= a;
    @(posedge clk);
    acc_req <= 1'h0;
    #1 `CHK("acc_ok", ok, acc_ok)
    `CHK("acc_idnf", !ok, acc_idnf)
    @(posedge clk);
  endtask : acc
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {rstn, psel, penable, pwrite, hw_rst, acc_req} = 6'h00;
    {paddr, pwdata, acc_lba, pwd_idx} = '0;
    fail_count = 0;
    check_count = 0;
    seed = 16243;
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    chk_id(16777216, 16383, 16383);
    for (int i = 0; i < 3; i++) begin
      cmd({1'h0, 7'($random(seed))}, 32'h0000_0000, 16'h0000);
      `CHK("abort", 1'h1, rd[1])
    end
    apb(1'h0, 8'h40, 32'h0000_0000);
    `CHK("slverr", 1'h1, err)
    // feature 02 right after a native read still sets the maximum
    cmd(8'hF8, 32'h0000_0000, 16'h0000);
    apb(1'h0, 8'h10, 32'h0000_0000);
    `CHK("native", native_max, rd[27:0])
    w1f = 1000 + {$random(seed)} % 1000;
    capf = w1f * 1008;
    cmd(8'hF8, 32'h0000_0000, 16'h0000);
    cmd(8'hF9, {8'hAF, 16'(w1f - 1), 8'h3F}, 16'h0201);
    `CHK("abort", 1'h0, rd[1])
    chk_id(capf, w1f, w1f);
    `CHK("locked", 1'h0, locked)
    cmd(8'hF8, 32'h0000_0000, 16'h0000);
    cmd(8'hF9, {8'hAF, 16'h0010, 8'h3F}, 16'h0001);
    `CHK("idnf", 1'h1, rd[2])
    chk_id(capf, w1f, w1f);
    cap = 1 + {$random(seed)} % 2000000;
    lba = cap - 1;
    cmd(8'hF8, 32'h0000_0000, 16'h0000);
    cmd(8'hF9, {4'hE, 4'(lba >> 24), 24'(lba)}, 16'h01FE);
    `CHK("abort", 1'h0, rd[1])
    chk_id(cap, geo(cap), geo(cap));
    acc(28'(lba), 1'h1);
    acc(28'(cap), 1'h0);
    cmd(8'hF8, 32'h0000_0000, 16'h0000);
    cmd(8'hF9, 32'hEFFF_FFFF, 16'h0000);
    `CHK("abort", 1'h1, rd[1])
    chk_id(cap, geo(cap), geo(cap));
    cmd(8'hF8, 32'h0000_0000, 16'h0000);
    cmd(8'hF9, 32'hE0FF_FFFF, 16'h0000);
    `CHK("abort", 1'h0, rd[1])
    chk_id(16777216, 16383, 16383);
    acc(28'h0FF_FFFF, 1'h1);
    hw_rst <= 1'h1;
    repeat (4) @(posedge clk);
    hw_rst <= 1'h0;
    repeat (4) @(posedge clk);
    chk_id(capf, w1f, w1f);
    for (int i = 0; i < 8; i++) begin
      pw[i] = $random(seed);
      apb(1'h1, 8'(32 + 4 * i), pw[i]);
    end
    cmd(8'hF9, 32'h0000_0000, 16'h0100);
    `CHK("locked", 1'h1, locked)
    for (int k = 0; k < 16; k++) begin
      pwd_idx <= 4'(k);
      @(posedge clk);
      #1 `CHK("pwd", (k % 2) ? pw[k / 2][31:16] : pw[k / 2][15:0], pwd_word)
      @(posedge clk);
    end
    @(posedge clk);
    cmd(8'hF9, 32'h0000_0000, 16'h0200);
    `CHK("abort", 1'h1, rd[1])
    `CHK("locked", 1'h1, locked)
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    complete_run();
  end
endmodule : max_address_limit_commands_tb
`default_nettype wire
